// File: rtl/bank_decoder_regs.svh
// Purpose: Offsets, reset values and vectors for the bank address decoder
// Assumes: Included once per compile unit through its guard
// Notes on behaviour
// - The program counter is 13 bits wide and spans an 8k word space.
// - Only the low 2k words exist and higher addresses wrap into them.
// - Fetching starts at address zero after reset and at four on interrupt.
// - Data memory has four banks of 128 locations of eight bits each.
// - The lowest 32 locations of every bank are special-function space.
// - General RAM sits at 20h-7Fh in bank 0 and A0h-BFh in bank 1.
// - The top sixteen locations of banks 1 to 3 share bank 0 70h-7Fh.
// - Unimplemented data addresses read zero and hold no storage.
// - Direct access takes seven bits from the opcode and two bank bits.
// - Bank bits high then low: 00, 01, 10, 11 pick banks 0 to 3.
// - Indirect access uses the pointer with the indirect bank bit on top.
`ifndef BANK_DECODER_REGS_SVH
`define BANK_DECODER_REGS_SVH

`define PC_WIDTH 13
`define FETCH_WIDTH 11
`define RESET_VECTOR 13'h0000
`define INTERRUPT_VECTOR 13'h0004

`define OFS_INDIRECT_DATA 7'h00
`define OFS_PROGRAM_COUNTER_LOW 7'h02
`define OFS_CORE_STATUS_FLAGS 7'h03
`define OFS_INDIRECT_POINTER 7'h04
`define OFS_PROGRAM_COUNTER_HIGH_LATCH 7'h0A

`define SPECIAL_SPACE_TOP 7'h1F
`define BANK1_RAM_TOP 7'h3F
`define SHARED_RAM_BASE 7'h70
`define RAM_BASE 7'h20
`define BANK1_RAM_INDEX 7'h60
`define SHARED_RAM_INDEX 7'h50
`define RAM_DEPTH 128

`define STATUS_INDIRECT_BANK_BIT 7
`define STATUS_BANK_SELECT_HIGH 6
`define STATUS_BANK_SELECT_LOW 5
`define STATUS_WRITE_MASK 8'hE7
`define STATUS_RESET 8'h18
`define POINTER_RESET 8'h00
`define HIGH_LATCH_RESET 8'h00
`define HIGH_LATCH_MASK 8'h1F

`endif

// File: rtl/bank_decoder_pkg.sv
// Purpose: Types shared by the bank address decoder
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Region codes select the read source and write target
package bank_decoder_pkg;

  typedef enum logic [2:0] {
    REGION_NONE = 3'b000,
    REGION_RAM = 3'b001,
    REGION_PCL = 3'b010,
    REGION_STATUS = 3'b011,
    REGION_POINTER = 3'b100,
    REGION_HIGH_LATCH = 3'b101
  } region_type;

  typedef logic [8:0] data_addr_type;

endpackage : bank_decoder_pkg

// File: rtl/memory_bank_address_decoder.sv
// Purpose: Program counter and banked data address decoder for the core
// Assumes: All inputs come from core logic on sys_clk
// Notes: Peripheral special registers are not held here and read zero
`timescale 1ns/1ps
`include "bank_decoder_regs.svh"

module memory_bank_address_decoder (
  input wire logic sys_clk, // Core clock, 250 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic pc_step, // Advance fetch by one word
  input wire logic pc_jump, // Load jump target
  input wire logic [10:0] jump_target, // Target of goto or call
  input wire logic interrupt_enter, // Enter interrupt vector
  input wire logic data_req, // Data access this cycle
  input wire logic data_we, // Access is a write
  input wire logic data_direct, // Direct (opcode) addressing
  input wire logic [6:0] opcode_addr, // Address bits from opcode
  input wire logic [7:0] data_wdata, // Write data
  output logic [12:0] pc_r, // Program counter
  output logic [10:0] fetch_addr_r, // Implemented fetch address
  output logic [7:0] data_rdata_r, // Read data
  output logic data_rvalid_r, // Read data valid pulse
  output logic [7:0] status_r, // Core status flags
  output bank_decoder_pkg::data_addr_type last_addr_r // Last decoded addr
);
  import bank_decoder_pkg::*;

  logic [12:0] pc_nxt;
  logic [10:0] fetch_addr_nxt;
  logic [7:0] status_nxt;
  logic [7:0] pointer_r;
  logic [7:0] pointer_nxt;
  logic [7:0] high_latch_r;
  logic [7:0] high_latch_nxt;
  logic [7:0] data_rdata_nxt;
  logic data_rvalid_nxt;
  data_addr_type last_addr_nxt;
  data_addr_type eff_addr;
  region_type region;
  logic [6:0] ram_idx;
  logic ram_we;
  logic wr_go;
  logic [7:0] ram_mem [0:`RAM_DEPTH-1];

  // Effective address formation
  // Direct offset 00h falls through to the pointer path
  always_comb begin
    if (data_direct && opcode_addr != `OFS_INDIRECT_DATA) begin
      eff_addr = {status_r[`STATUS_BANK_SELECT_HIGH],
                  status_r[`STATUS_BANK_SELECT_LOW], opcode_addr};
    end else begin
      eff_addr = {status_r[`STATUS_INDIRECT_BANK_BIT], pointer_r};
    end
  end

  // Region decode of the nine-bit address
  // RAM index map: 00h-4Fh bank 0 20h-6Fh, 50h-5Fh shared top
  // sixteen, 60h-7Fh bank 1 A0h-BFh; every other offset keeps
  // no storage
  always_comb begin
    region = REGION_NONE;
    ram_idx = 7'h00;
    if (eff_addr[6:0] == `OFS_PROGRAM_COUNTER_LOW) begin
      region = REGION_PCL;
    end else if (eff_addr[6:0] == `OFS_CORE_STATUS_FLAGS) begin
      region = REGION_STATUS;
    end else if (eff_addr[6:0] == `OFS_INDIRECT_POINTER) begin
      region = REGION_POINTER;
    end else if (eff_addr[6:0] == `OFS_PROGRAM_COUNTER_HIGH_LATCH) begin
      region = REGION_HIGH_LATCH;
    end else if (eff_addr[6:0] <= `SPECIAL_SPACE_TOP) begin
      region = REGION_NONE;
    end else if (eff_addr[6:0] >= `SHARED_RAM_BASE) begin
      region = REGION_RAM;
      ram_idx = `SHARED_RAM_INDEX + {3'h0, eff_addr[3:0]};
    end else if (eff_addr[8:7] == 2'b00) begin
      region = REGION_RAM;
      ram_idx = eff_addr[6:0] - `RAM_BASE;
    end else if (eff_addr[8:7] == 2'b01 &&
                 eff_addr[6:0] <= `BANK1_RAM_TOP) begin
      region = REGION_RAM;
      ram_idx = `BANK1_RAM_INDEX + (eff_addr[6:0] - `RAM_BASE);
    end
  end

  // A write is taken on any rising edge with a request that has data_we set
  assign wr_go = data_req && data_we;
  assign ram_we = wr_go && region == REGION_RAM;

  // Program counter: interrupt, then PROGRAM_COUNTER_LOW write, jump, step
  always_comb begin
    pc_nxt = pc_r;
    if (interrupt_enter) begin
      pc_nxt = `INTERRUPT_VECTOR;
    end else if (wr_go && region == REGION_PCL) begin
      pc_nxt = {high_latch_r[4:0], data_wdata};
    end else if (pc_jump) begin
      // Jump keeps latch bits 4:3 only
      pc_nxt = {high_latch_r[4:3], jump_target};
    end else if (pc_step) begin
      pc_nxt = pc_r + 13'h0001;
    end
    // Upper two counter bits never reach the fetch port
    fetch_addr_nxt = pc_nxt[10:0];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pc_r <= `RESET_VECTOR;
      fetch_addr_r <= 11'h000;
    end else begin
      pc_r <= pc_nxt;
      fetch_addr_r <= fetch_addr_nxt;
    end
  end

  // Core register writes; peripheral offsets drop the data
  always_comb begin
    status_nxt = status_r;
    pointer_nxt = pointer_r;
    high_latch_nxt = high_latch_r;
    if (wr_go) begin
      unique case (region)
        REGION_STATUS: begin
          // Power flag bits 4:3 stay as reset left them
          status_nxt = (status_r & ~`STATUS_WRITE_MASK) |
                       (data_wdata & `STATUS_WRITE_MASK);
        end
        REGION_POINTER: begin
          pointer_nxt = data_wdata;
        end
        REGION_HIGH_LATCH: begin
          // Only five latch bits exist
          high_latch_nxt = data_wdata & `HIGH_LATCH_MASK;
        end
        REGION_PCL: begin
          // Counter load is done in the counter group
          pointer_nxt = pointer_r;
        end
        REGION_RAM: begin
          // Array is written in its own process
          pointer_nxt = pointer_r;
        end
        REGION_NONE: begin
          // Peripheral or unimplemented offset, data dropped
          pointer_nxt = pointer_r;
        end
        default: begin
          pointer_nxt = pointer_r;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_r <= `STATUS_RESET;
      pointer_r <= `POINTER_RESET;
      high_latch_r <= `HIGH_LATCH_RESET;
    end else begin
      status_r <= status_nxt;
      pointer_r <= pointer_nxt;
      high_latch_r <= high_latch_nxt;
    end
  end

  // Read path; data returns to zero when no read is answered
  always_comb begin
    data_rdata_nxt = 8'h00;
    data_rvalid_nxt = data_req && !data_we;
    // Trace holds the last decoded address between accesses
    last_addr_nxt = data_req ? eff_addr : last_addr_r;
    if (data_rvalid_nxt) begin
      unique case (region)
        REGION_RAM: begin
          // Old contents win over a write in the same cycle
          data_rdata_nxt = ram_mem[ram_idx];
        end
        REGION_PCL: begin
          // Low counter byte, not the latch
          data_rdata_nxt = pc_r[7:0];
        end
        REGION_STATUS: begin
          data_rdata_nxt = status_r;
        end
        REGION_POINTER: begin
          data_rdata_nxt = pointer_r;
        end
        REGION_HIGH_LATCH: begin
          data_rdata_nxt = high_latch_r;
        end
        REGION_NONE: begin
          data_rdata_nxt = 8'h00;
        end
        default: begin
          data_rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_rdata_r <= 8'h00;
      data_rvalid_r <= 1'b0;
      last_addr_r <= 9'h000;
    end else begin
      data_rdata_r <= data_rdata_nxt;
      data_rvalid_r <= data_rvalid_nxt;
      last_addr_r <= last_addr_nxt;
    end
  end

  // Single shared RAM, 128 bytes; RAM contents are not reset
  // Bank 0 top sixteen and the mirrored bank tops share 50h-5Fh
  always_ff @(posedge sys_clk) begin
    if (ram_we) begin
      ram_mem[ram_idx] <= data_wdata;
    end
  end

endmodule : memory_bank_address_decoder

// File: dv/mbad_sva.sv
// Purpose: Port checker for the bank address decoder
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every decoder instance
`timescale 1ns/1ps
module mbad_sva (
  input wire logic sys_clk, rst_n, pc_step, pc_jump, interrupt_enter,
  input wire logic data_req, data_we, data_direct, data_rvalid_r,
  input wire logic [10:0] jump_target, fetch_addr_r,
  input wire logic [6:0] opcode_addr,
  input wire logic [7:0] data_wdata, data_rdata_r, status_r,
  input wire logic [12:0] pc_r,
  input wire bank_decoder_pkg::data_addr_type last_addr_r
);
  import bank_decoder_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_read;
    data_req && !data_we;
  endsequence
  sequence s_quiet;
    !interrupt_enter && !(data_req && data_we);
  endsequence
  chk_fetch_wrap: assert property (fetch_addr_r == pc_r[10:0])
    else $error("fetch address off");
  chk_irq_vector: assert property (interrupt_enter |=> pc_r == 13'h0004)
    else $error("interrupt vector off");
  chk_reset_start: assert property ($rose(rst_n) |-> pc_r == 13'h0000)
    else $error("reset vector off");
  chk_step_count: assert property (pc_step && !pc_jump ##0 s_quiet
    |=> pc_r == $past(pc_r) + 13'h0001) else $error("pc step off");
  chk_jump_load: assert property (pc_jump ##0 s_quiet
    |=> pc_r[10:0] == $past(jump_target)) else $error("jump off");
  chk_read_valid: assert property (s_read |=> data_rvalid_r)
    else $error("read not answered");
  chk_rdata_idle: assert property (!data_rvalid_r
    |-> data_rdata_r == 8'h00) else $error("read data not cleared");
  chk_direct_addr: assert property (data_req && data_direct
    && opcode_addr != 7'h00 |=> last_addr_r ==
    {$past(status_r[6:5]), $past(opcode_addr)}) else $error("direct addr");
  chk_unimpl_zero: assert property (s_read ##0 data_direct
    && status_r[6:5] != 2'b00 && opcode_addr inside {[7'h40:7'h6F]}
    |=> data_rdata_r == 8'h00) else $error("unimplemented read");
endmodule : mbad_sva

bind memory_bank_address_decoder mbad_sva u_sva (.*);

// File: dv/core_model.sv
// Purpose: Core side data access driver
// Assumes: Called at a falling edge
// Notes: Idle bus carries changing garbage
`timescale 1ns/1ps
module core_model (
  input wire logic sys_clk, // Core clock
  output logic data_req, data_we, data_direct, // Access controls
  output logic [6:0] opcode_addr, // Opcode address bits
  output logic [7:0] data_wdata // Write data
);
  initial begin
    data_req = 1'b0;
    {data_we, data_direct, opcode_addr, data_wdata} = 17'h00000;
  end
  task automatic acc(input int w, dr, a, input logic [7:0] d);
    {data_req, data_we, data_direct} = {1'b1, w[0], dr[0]};
    {opcode_addr, data_wdata} = {a[6:0], d};
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : acc
  task automatic idle();
    data_req = 1'b0;
    {opcode_addr, data_wdata} = ~{opcode_addr, data_wdata};
  endtask : idle
endmodule : core_model

// File: dv/test_memory_bank_address_decoder.sv
// Purpose: Self-checking bench for the bank address decoder
// Assumes: Core model drives the data side
// Notes: Reads of never-written RAM are not compared
`timescale 1ns/1ps
module test_memory_bank_address_decoder;
  logic sys_clk, rst_n, pc_step, pc_jump, interrupt_enter;
  logic data_req, data_we, data_direct, data_rvalid_r;
  logic [10:0] jump_target, fetch_addr_r;
  logic [6:0] opcode_addr;
  logic [7:0] data_wdata, data_rdata_r, status_r, st, ptr, d;
  logic [12:0] pc_r;
  bank_decoder_pkg::data_addr_type last_addr_r;
  int err_total, check_count, cyc, seed, a, w, dr;
  int ram[int];
  memory_bank_address_decoder DUT (.*);
  core_model u_core (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(string n, logic [12:0] e, logic [12:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic int phys(int x);
    if (x % 128 >= 'h70) return x % 128;
    if (x % 128 >= 'h20 && (x < 128 || (x < 256 && x % 128 < 'h40)))
      return x;
    return -1;
  endfunction : phys
  task automatic access(int x, int wr, int dir, logic [7:0] v);
    int o;
    int p;
    logic [7:0] e;
    o = x % 128;
    p = phys(x);
    e = o == 3 ? st : o == 4 ? ptr : ram.exists(p) ? ram[p] : 8'h00;
    u_core.acc(wr, dir, x, v);
    chk("rvalid", wr == 0, data_rvalid_r);
    if (wr == 0 && (p < 0 || ram.exists(p)))
      chk("rdata", e, data_rdata_r);
    chk("addr", x, last_addr_r);
    if (wr != 0 && o == 3) st = (v & 8'hE7) | (st & 8'h18);
    else if (wr != 0 && o == 4) ptr = v;
    else if (wr != 0 && p >= 0) ram[p] = v;
    chk("status", st, status_r);
  endtask : access
  initial begin
    {rst_n, pc_step, pc_jump, interrupt_enter, jump_target} = 15'h0000;
    {st, ptr, seed} = {8'h18, 8'h00, 32'h6A90113F};
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    chk("pc", 13'h0000, pc_r);
    {pc_jump, jump_target} = {1'b1, 11'h7FF};
    @(negedge sys_clk);
    {pc_jump, pc_step} = 2'b01;
    @(negedge sys_clk);
    {pc_step, interrupt_enter} = 2'b01;
    chk("pc", 13'h0800, pc_r);
    chk("fetch", 13'h0000, fetch_addr_r);
    @(negedge sys_clk);
    interrupt_enter = 1'b0;
    chk("pc", 13'h0004, pc_r);
    u_core.acc(1, 1, 'h0A, 8'hFF);
    u_core.acc(0, 1, 'h0A, 8'h00);
    chk("latch", 13'h001F, data_rdata_r);
    u_core.acc(1, 1, 'h02, 8'h34);
    chk("pc", 13'h1F34, pc_r);
    chk("fetch", 13'h0734, fetch_addr_r);
    {pc_jump, jump_target} = {1'b1, 11'h123};
    u_core.acc(0, 1, 'h02, 8'h00);
    pc_jump = 1'b0;
    chk("pcl", 13'h0034, data_rdata_r);
    chk("pc", 13'h1923, pc_r);
    u_core.acc(0, 1, 'h00, 8'h00);
    chk("rdata", 13'h0000, data_rdata_r);
    chk("addr", 13'h0000, last_addr_r);
    repeat (400) begin
      a = $random(seed) & 'h1FF;
      {w, dr, d} = {$random(seed) & 1, $random(seed) & 1, 8'($random(seed))};
      if (a % 128 inside {0, 2, 10}) a = a + 1;
      access(int'(st[6:5]) * 128 + 3, 1, 1, {a[8], a[8:7], 5'h00});
      if (dr == 0) access((a & 'h180) | 4, 1, 1, a[7:0]);
      access(a, w, dr, d);
    end
    u_core.idle();
    give_verdict();
  end
endmodule : test_memory_bank_address_decoder
